// [core/toc_pkg.sv]
// Constants, encodings and bus carriers of the 16-bit timer compare block.
// Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
package toc_pkg;

   localparam int unsigned TOC_AW = 8;
   localparam int unsigned TOC_NCH = 3;

   // Register byte offsets; each register takes one aligned word
   localparam logic [7:0] TOC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] TOC_FORCE_OFS  = 8'h04;
   localparam logic [7:0] TOC_FLAGS_OFS  = 8'h08;
   localparam logic [7:0] TOC_CNT_LO_OFS = 8'h0c;
   localparam logic [7:0] TOC_CNT_HI_OFS = 8'h10;
   localparam logic [7:0] TOC_MLO_BASE   = 8'h14;
   localparam logic [7:0] TOC_MHI_BASE   = 8'h18;
   localparam logic [7:0] TOC_CH_STRIDE  = 8'h08;
   localparam logic [7:0] TOC_LAST_OFS   = 8'h28;

   // Control word field positions, and the overflow bit of the flags word
   localparam int unsigned TOC_WGM_LSB  = 0;
   localparam int unsigned TOC_DIV_LSB  = 4;
   localparam int unsigned TOC_ACT_LSB  = 8;
   localparam int unsigned TOC_IEN_LSB  = 16;
   localparam int unsigned TOC_OVIE_BIT = 19;
   localparam int unsigned TOC_DIR_LSB  = 20;
   localparam int unsigned TOC_OVF_BIT  = 3;

   // Waveform modes handled by the counter
   localparam logic [3:0] TOC_WGM_NORMAL  = 4'h0;
   localparam logic [3:0] TOC_WGM_CTC_A   = 4'h4;
   localparam logic [3:0] TOC_WGM_FAST8   = 4'h5;
   localparam logic [3:0] TOC_WGM_FAST9   = 4'h6;
   localparam logic [3:0] TOC_WGM_FAST10  = 4'h7;
   localparam logic [3:0] TOC_WGM_CTC_ICR = 4'hc;
   localparam logic [3:0] TOC_WGM_FAST_A  = 4'hf;

   localparam logic [15:0] TOC_MAX    = 16'hffff;
   localparam logic [15:0] TOC_BOTTOM = 16'h0000;
   localparam logic [15:0] TOC_TOP8   = 16'h00ff;
   localparam logic [15:0] TOC_TOP9   = 16'h01ff;
   localparam logic [15:0] TOC_TOP10  = 16'h03ff;

   // Output actions; in PWM modes 2 is non-inverted and 3 inverted
   localparam logic [1:0] TOC_ACT_NONE   = 2'h0;
   localparam logic [1:0] TOC_ACT_TOGGLE = 2'h1;
   localparam logic [1:0] TOC_ACT_CLEAR  = 2'h2;
   localparam logic [1:0] TOC_ACT_SET    = 2'h3;

   localparam logic [1:0] TOC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TOC_RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {TOC_WR_WAIT = 1'b0, TOC_WR_RESP = 1'b1} toc_wr_e;
   typedef enum logic [0:0] {TOC_RD_IDLE = 1'b0, TOC_RD_DATA = 1'b1} toc_rd_e;

   typedef struct packed {
      logic              awvalid;
      logic [TOC_AW-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [TOC_AW-1:0] araddr;
      logic              rready;
   } toc_axi_req_s;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } toc_axi_rsp_s;

   typedef struct packed {
      logic [TOC_NCH-1:0] value;
      logic [TOC_NCH-1:0] oe;
   } toc_pin_s;

endpackage

// [core/toc_timer16_compare.sv]
// 16-bit timer/counter with three output compare channels and AXI4-Lite
// register access. Assumes synchronous inputs and one 10 MHz clock.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// Operation
// - Enabled set flag requests an interrupt; acknowledge clears it.
// - Writing one to a flag bit clears it; zero leaves it.
// - Channel A match value can be the counter TOP.
// - PWM modes double buffer match values, loaded at TOP; others bypass.
// - CPU reaches the buffer when buffering is active, else active value.
// - Only CPU writes change match values; reads skip the high latch.
// - High byte goes to shared latch; low byte write loads 16 bits.
// - Force strobe acts like a match on output only, non-PWM only.
// - Counter write suppresses all matches at the next timer tick.
// - Counter written with TOP loses that match and runs to maximum.
// - Output state holds across waveform mode changes.
// - Action bit changes switch the pin override immediately.
// - New action applies from next match, or at once by force.
// - Reset clears every output state bit.
// - Nonzero action puts output state on pin; direction bit gates it.
// - Action zero leaves output state unchanged on a match.
// - Mode bits set counting; action bits set the output behaviour.
// - Normal mode always counts up and wraps from maximum to zero.
// - Normal mode overflow flag sets when counter becomes zero.
// - Normal mode accepts a new counter value at any time.
module toc_timer16_compare
   import toc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire toc_axi_req_s       axi_req,
   output toc_axi_rsp_s            axi_rsp,
   input  wire logic [TOC_NCH-1:0] port_value,
   input  wire logic [3:0]         irq_ack,
   output logic [3:0]              irq_req,
   output toc_pin_s                pin
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic toc_is_pwm(input logic [3:0] m);
      return !(m == TOC_WGM_NORMAL || m == TOC_WGM_CTC_A ||
               m == TOC_WGM_CTC_ICR);
   endfunction

   // No capture register here, so the capture-defined tops count to MAX
   function automatic logic [15:0] toc_top(input logic [3:0]  m,
                                           input logic [15:0] ch_a);
      case (m)
         TOC_WGM_CTC_A, TOC_WGM_FAST_A: toc_top = ch_a;
         TOC_WGM_FAST8:                 toc_top = TOC_TOP8;
         TOC_WGM_FAST9:                 toc_top = TOC_TOP9;
         TOC_WGM_FAST10:                toc_top = TOC_TOP10;
         default:                       toc_top = TOC_MAX;
      endcase
   endfunction

   function automatic logic toc_mapped(input logic [TOC_AW-1:0] a);
      return a[1:0] == 2'b00 && a <= TOC_LAST_OFS;
   endfunction

   function automatic logic [7:0] toc_word(input logic [TOC_AW-1:0] a);
      return {a[7:2], 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake state
   toc_wr_e           wr_state_r, wr_state_nxt;
   toc_rd_e           rd_state_r, rd_state_nxt;
   logic              aw_got_r, aw_got_nxt;
   logic              w_got_r, w_got_nxt;
   logic [TOC_AW-1:0] awaddr_r, awaddr_nxt;
   logic [31:0]       wdata_r, wdata_nxt;
   logic [3:0]        wstrb_r, wstrb_nxt;
   logic [1:0]        bresp_r, bresp_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic [1:0]        rresp_r, rresp_nxt;

   // Timer state
   logic [3:0]           wgm_r, wgm_nxt;
   logic [3:0]           div_r, div_nxt;
   logic [3:0]           div_cnt_r, div_cnt_nxt;
   logic [5:0]           act_r, act_nxt;
   logic [TOC_NCH-1:0]   ien_r, ien_nxt;
   logic                 ovie_r, ovie_nxt;
   logic [TOC_NCH-1:0]   dir_r, dir_nxt;
   logic [15:0]          count_r, count_nxt;
   logic [7:0]           temp_r, temp_nxt;
   logic [15:0]          ocr_r [TOC_NCH];
   logic [15:0]          ocr_nxt [TOC_NCH];
   logic [15:0]          obuf_r [TOC_NCH];
   logic [15:0]          obuf_nxt [TOC_NCH];
   logic [TOC_NCH-1:0]   mflag_r, mflag_nxt;
   logic                 ovf_r, ovf_nxt;
   logic [TOC_NCH-1:0]   ostate_r, ostate_nxt;
   logic                 block_r, block_nxt;

   logic              aw_hs, w_hs, ar_hs, do_write, wr_en, cnt_wr, rd_cnt_lo;
   logic [TOC_AW-1:0] wa;
   logic [31:0]       wd;
   logic [3:0]        ws;
   logic              tick, pwm, top_hit, wrap;
   logic [15:0]       top;
   logic [TOC_NCH-1:0] hit, frc, w1c;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: address and data taken in either order, one at a time
   assign axi_rsp.awready = wr_state_r == TOC_WR_WAIT && !aw_got_r;
   assign axi_rsp.wready  = wr_state_r == TOC_WR_WAIT && !w_got_r;
   assign axi_rsp.bvalid  = wr_state_r == TOC_WR_RESP;
   assign axi_rsp.bresp   = bresp_r;
   assign axi_rsp.arready = rd_state_r == TOC_RD_IDLE;
   assign axi_rsp.rvalid  = rd_state_r == TOC_RD_DATA;
   assign axi_rsp.rdata   = rdata_r;
   assign axi_rsp.rresp   = rresp_r;

   assign aw_hs    = axi_req.awvalid && axi_rsp.awready;
   assign w_hs     = axi_req.wvalid && axi_rsp.wready;
   assign ar_hs    = axi_req.arvalid && axi_rsp.arready;
   assign wa       = aw_got_r ? awaddr_r : axi_req.awaddr;
   assign wd       = w_got_r ? wdata_r : axi_req.wdata;
   assign ws       = w_got_r ? wstrb_r : axi_req.wstrb;
   assign do_write = wr_state_r == TOC_WR_WAIT && (aw_got_r || aw_hs) &&
                     (w_got_r || w_hs);
   // Registers are one byte wide or hold whole fields in lane 0 and up;
   // a write without lane 0 is acknowledged but stores nothing
   assign wr_en     = do_write && ws[0] && toc_mapped(wa);
   assign cnt_wr    = wr_en && toc_word(wa) == TOC_CNT_LO_OFS;
   assign rd_cnt_lo = ar_hs && toc_word(axi_req.araddr) == TOC_CNT_LO_OFS;

   always_comb begin
      logic [7:0] ra;
      ra           = toc_word(axi_req.araddr);
      wr_state_nxt = wr_state_r;
      rd_state_nxt = rd_state_r;
      aw_got_nxt   = aw_got_r;
      w_got_nxt    = w_got_r;
      awaddr_nxt   = awaddr_r;
      wdata_nxt    = wdata_r;
      wstrb_nxt    = wstrb_r;
      bresp_nxt    = bresp_r;
      rdata_nxt    = rdata_r;
      rresp_nxt    = rresp_r;
      case (wr_state_r)
         TOC_WR_WAIT: begin
            if (aw_hs) begin
               aw_got_nxt = 1'b1;
               awaddr_nxt = axi_req.awaddr;
            end
            if (w_hs) begin
               w_got_nxt = 1'b1;
               wdata_nxt = axi_req.wdata;
               wstrb_nxt = axi_req.wstrb;
            end
            if (do_write) begin
               wr_state_nxt = TOC_WR_RESP;
               bresp_nxt    = toc_mapped(wa) ? TOC_RESP_OKAY : TOC_RESP_SLVERR;
            end
         end
         TOC_WR_RESP: begin
            if (axi_req.bready) begin
               wr_state_nxt = TOC_WR_WAIT;
               aw_got_nxt   = 1'b0;
               w_got_nxt    = 1'b0;
            end
         end
         default: wr_state_nxt = TOC_WR_WAIT;
      endcase
      case (rd_state_r)
         TOC_RD_IDLE: begin
            if (ar_hs) begin
               rd_state_nxt = TOC_RD_DATA;
               rdata_nxt    = 32'h0000_0000;
               rresp_nxt    = toc_mapped(axi_req.araddr) ? TOC_RESP_OKAY
                                                          : TOC_RESP_SLVERR;
               case (ra)
                  TOC_CTRL_OFS: begin
                     rdata_nxt[TOC_WGM_LSB +: 4]       = wgm_r;
                     rdata_nxt[TOC_DIV_LSB +: 4]       = div_r;
                     rdata_nxt[TOC_ACT_LSB +: 6]       = act_r;
                     rdata_nxt[TOC_IEN_LSB +: TOC_NCH] = ien_r;
                     rdata_nxt[TOC_OVIE_BIT]           = ovie_r;
                     rdata_nxt[TOC_DIR_LSB +: TOC_NCH] = dir_r;
                  end
                  TOC_FLAGS_OFS: rdata_nxt[3:0] = {ovf_r, mflag_r};
                  TOC_CNT_LO_OFS: rdata_nxt[7:0] = count_r[7:0];
                  TOC_CNT_HI_OFS: rdata_nxt[7:0] = temp_r;
                  default: begin
                     // Match values read straight from the buffer in PWM modes, else the active register
                     for (int i = 0; i < TOC_NCH; i++) begin
                        if (ra == TOC_MLO_BASE + 8'(i) * TOC_CH_STRIDE)
                           rdata_nxt[7:0] = pwm ? obuf_r[i][7:0]
                                                : ocr_r[i][7:0];
                        if (ra == TOC_MHI_BASE + 8'(i) * TOC_CH_STRIDE)
                           rdata_nxt[7:0] = pwm ? obuf_r[i][15:8]
                                                : ocr_r[i][15:8];
                     end
                  end
               endcase
            end
         end
         TOC_RD_DATA: if (axi_req.rready) rd_state_nxt = TOC_RD_IDLE;
         default: rd_state_nxt = TOC_RD_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_state_r <= TOC_WR_WAIT;
         rd_state_r <= TOC_RD_IDLE;
         aw_got_r   <= 1'b0;
         w_got_r    <= 1'b0;
         awaddr_r   <= '0;
         wdata_r    <= 32'h0000_0000;
         wstrb_r    <= 4'h0;
         bresp_r    <= TOC_RESP_OKAY;
         rdata_r    <= 32'h0000_0000;
         rresp_r    <= TOC_RESP_OKAY;
      end else begin
         wr_state_r <= wr_state_nxt;
         rd_state_r <= rd_state_nxt;
         aw_got_r   <= aw_got_nxt;
         w_got_r    <= w_got_nxt;
         awaddr_r   <= awaddr_nxt;
         wdata_r    <= wdata_nxt;
         wstrb_r    <= wstrb_nxt;
         bresp_r    <= bresp_nxt;
         rdata_r    <= rdata_nxt;
         rresp_r    <= rresp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer clock enable: divide by div_r, zero stops the timer
   assign tick = div_r != 4'h0 && div_cnt_r == div_r - 4'h1;
   assign pwm  = toc_is_pwm(wgm_r);
   assign top  = toc_top(wgm_r, ocr_r[0]);
   // A blocked tick also loses the TOP clear, so the count runs on
   assign top_hit = tick && !block_r && wgm_r != TOC_WGM_NORMAL &&
                    count_r == top;
   assign wrap = tick && !cnt_wr && (pwm ? top_hit : count_r == TOC_MAX);
   assign w1c  = (wr_en && toc_word(wa) == TOC_FLAGS_OFS) ? wd[2:0] : 3'h0;
   assign frc  = (wr_en && toc_word(wa) == TOC_FORCE_OFS && !pwm)
                 ? wd[2:0] : 3'h0;

   for (genvar g = 0; g < TOC_NCH; g++) begin : g_cmp
      assign hit[g] = tick && !block_r && count_r == ocr_r[g];
      // Override follows the action bits with no pipeline
      assign pin.value[g] = act_r[2*g +: 2] != TOC_ACT_NONE ? ostate_r[g]
                                                             : port_value[g];
   end
   assign pin.oe  = dir_r;
   assign irq_req = {ovf_r & ovie_r, mflag_r & ien_r};

   always_comb begin
      logic [1:0] act;
      act         = TOC_ACT_NONE;
      wgm_nxt     = wgm_r;
      div_nxt     = div_r;
      act_nxt     = act_r;
      ien_nxt     = ien_r;
      ovie_nxt    = ovie_r;
      dir_nxt     = dir_r;
      temp_nxt    = temp_r;
      ostate_nxt  = ostate_r;
      ocr_nxt     = ocr_r;
      obuf_nxt    = obuf_r;
      div_cnt_nxt = (div_r == 4'h0 || tick) ? 4'h0 : div_cnt_r + 4'h1;
      // Only the tick right after a counter write is blocked
      block_nxt   = cnt_wr || (block_r && !tick);
      count_nxt   = count_r;
      if (cnt_wr)
         count_nxt = {temp_r, wd[7:0]};
      else if (tick)
         count_nxt = top_hit ? TOC_BOTTOM : count_r + 16'h0001;
      // Set wins over both clears
      ovf_nxt = wrap || (ovf_r && !irq_ack[3]);
      if (wr_en && toc_word(wa) == TOC_FLAGS_OFS && wd[TOC_OVF_BIT])
         ovf_nxt = wrap;
      if (rd_cnt_lo) temp_nxt = count_r[15:8];
      if (wr_en && toc_word(wa) == TOC_CNT_HI_OFS) temp_nxt = wd[7:0];
      if (wr_en && toc_word(wa) == TOC_CTRL_OFS) begin
         wgm_nxt  = wd[TOC_WGM_LSB +: 4];
         div_nxt  = wd[TOC_DIV_LSB +: 4];
         act_nxt  = wd[TOC_ACT_LSB +: 6];
         ien_nxt  = wd[TOC_IEN_LSB +: TOC_NCH];
         ovie_nxt = wd[TOC_OVIE_BIT];
         dir_nxt  = wd[TOC_DIR_LSB +: TOC_NCH];
      end
      for (int i = 0; i < TOC_NCH; i++) begin
         act = act_r[2*i +: 2];
         mflag_nxt[i] = hit[i] || (mflag_r[i] && !w1c[i] && !irq_ack[i]);
         if (pwm) begin
            if (hit[i] && act == TOC_ACT_CLEAR) ostate_nxt[i] = 1'b0;
            if (hit[i] && act == TOC_ACT_SET)   ostate_nxt[i] = 1'b1;
            // Action at BOTTOM wins, so a value equal to TOP gives a level
            if (top_hit && act == TOC_ACT_CLEAR) ostate_nxt[i] = 1'b1;
            if (top_hit && act == TOC_ACT_SET)   ostate_nxt[i] = 1'b0;
            if (top_hit) ocr_nxt[i] = obuf_r[i];
         end else if (hit[i] || frc[i]) begin
            case (act)
               TOC_ACT_TOGGLE: ostate_nxt[i] = !ostate_r[i];
               TOC_ACT_CLEAR:  ostate_nxt[i] = 1'b0;
               TOC_ACT_SET:    ostate_nxt[i] = 1'b1;
               default:        ostate_nxt[i] = ostate_r[i];
            endcase
         end
         if (wr_en && toc_word(wa) == TOC_MHI_BASE + 8'(i) * TOC_CH_STRIDE)
            temp_nxt = wd[7:0];
         if (wr_en && toc_word(wa) == TOC_MLO_BASE + 8'(i) * TOC_CH_STRIDE) begin
            if (pwm)
               obuf_nxt[i] = {temp_r, wd[7:0]};
            else
               ocr_nxt[i] = {temp_r, wd[7:0]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wgm_r     <= TOC_WGM_NORMAL;
         div_r     <= 4'h0;
         div_cnt_r <= 4'h0;
         act_r     <= 6'h00;
         ien_r     <= 3'h0;
         ovie_r    <= 1'b0;
         dir_r     <= 3'h0;
         count_r   <= TOC_BOTTOM;
         temp_r    <= 8'h00;
         mflag_r   <= 3'h0;
         ovf_r     <= 1'b0;
         ostate_r  <= 3'h0;
         block_r   <= 1'b0;
         for (int i = 0; i < TOC_NCH; i++) begin
            ocr_r[i]  <= 16'h0000;
            obuf_r[i] <= 16'h0000;
         end
      end else begin
         wgm_r     <= wgm_nxt;
         div_r     <= div_nxt;
         div_cnt_r <= div_cnt_nxt;
         act_r     <= act_nxt;
         ien_r     <= ien_nxt;
         ovie_r    <= ovie_nxt;
         dir_r     <= dir_nxt;
         count_r   <= count_nxt;
         temp_r    <= temp_nxt;
         mflag_r   <= mflag_nxt;
         ovf_r     <= ovf_nxt;
         ostate_r  <= ostate_nxt;
         block_r   <= block_nxt;
         ocr_r     <= ocr_nxt;
         obuf_r    <= obuf_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_cnt_written;
      cnt_wr;
   endsequence
   sequence s_next_tick;
      !cnt_wr && tick;
   endsequence

   a_flag_on_hit: assert property (hit[0] |=> mflag_r[0])
      else $error("match did not set channel A flag");
   a_ack_clears: assert property (
      mflag_r[1] && irq_ack[1] && !hit[1] |=> !mflag_r[1])
      else $error("acknowledge did not clear channel B flag");
   a_w1c_flag: assert property (
      mflag_r[2] && w1c[2] && !hit[2] |=> !mflag_r[2])
      else $error("write one did not clear channel C flag");
   a_w0_keeps: assert property (
      mflag_r[0] && wr_en && toc_word(wa) == TOC_FLAGS_OFS && !wd[0] &&
      !irq_ack[0] |=> mflag_r[0])
      else $error("write zero cleared a flag");
   a_write_blocks: assert property (
      s_cnt_written ##1 s_next_tick |=> mflag_r == $past(mflag_r, 1)
      || (mflag_r & ~$past(mflag_r, 1)) == 3'h0)
      else $error("match fired right after counter write");
   a_normal_wrap: assert property (
      wgm_r == TOC_WGM_NORMAL && tick && !cnt_wr && count_r == TOC_MAX
      |=> count_r == TOC_BOTTOM && ovf_r)
      else $error("normal mode wrap or overflow wrong");
   a_ctc_top: assert property (
      wgm_r == TOC_WGM_CTC_A && tick && !block_r && !cnt_wr &&
      count_r == ocr_r[0] |=> count_r == TOC_BOTTOM)
      else $error("counter not cleared at channel A top");
   a_dbuf_hold: assert property (
      pwm && !top_hit |=> ocr_r[0] == $past(ocr_r[0], 1))
      else $error("active value changed away from TOP in PWM");
   a_force_toggle: assert property (
      frc[0] && !hit[0] && act_r[1:0] == TOC_ACT_TOGGLE
      |=> ostate_r[0] != $past(ostate_r[0], 1) && !$rose(mflag_r[0]))
      else $error("force strobe misbehaved");
   a_pin_override: assert property (
      act_r[1:0] != TOC_ACT_NONE |-> pin.value[0] == ostate_r[0])
      else $error("output state not on pin");
   a_reset_state: assert property (
      @(posedge clk) disable iff (1'b0) rst |=> ostate_r == 3'h0)
      else $error("reset left output state set");

endmodule

// [verification/toc_cpu_model.sv]
// CPU side of the register bus: an AXI4-Lite master, one access at a time.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/1ns
module toc_cpu_model
   import toc_pkg::*;
(
   input  wire logic         clk,
   output toc_axi_req_s      axi_req,
   input  wire toc_axi_rsp_s axi_rsp
);
   initial axi_req = '0;
   ////////////////////////////////////////////////////////////////////////
   // Address and data are offered together and dropped as each is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
                     output logic [1:0] resp);
      logic done;
      @(posedge clk);
      axi_req.awaddr <= a;
      axi_req.wdata <= v;
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(posedge clk);
         if (axi_rsp.awready)
            axi_req.awvalid <= 1'b0;
         if (axi_rsp.wready)
            axi_req.wvalid <= 1'b0;
         if (axi_rsp.bvalid) begin
            axi_req.bready <= 1'b0;
            resp = axi_rsp.bresp;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] resp);
      logic done;
      @(posedge clk);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      done = 1'b0;
      while (!done) begin
         @(posedge clk);
         if (axi_rsp.arready)
            axi_req.arvalid <= 1'b0;
         if (axi_rsp.rvalid) begin
            axi_req.rready <= 1'b0;
            d = axi_rsp.rdata;
            resp = axi_rsp.rresp;
            done = 1'b1;
         end
      end
   endtask
endmodule

// [verification/test_timer16_output_compare.sv]
// Self-checking bench of the timer compare block through its register bus.
// Assumes toc_cpu_model as bus master and one 10 MHz clock.
`timescale 1ns/1ns
module test_timer16_output_compare
   import toc_pkg::*;
;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   toc_axi_req_s axi_req;
   toc_axi_rsp_s axi_rsp;
   logic [2:0]   port_value = 3'h0;
   logic [3:0]   irq_ack = 4'h0;
   logic [3:0]   irq_req;
   toc_pin_s     pin;
   logic [31:0]  d;
   logic [1:0]   r;
   int           err_total = 0;
   int           n_compared = 0;
   int           cyc = 0;
   always #50 clk = ~clk;
   toc_timer16_compare u_toc_timer16_compare (.clk(clk), .rst(rst),
      .axi_req(axi_req), .axi_rsp(axi_rsp), .port_value(port_value),
      .irq_ack(irq_ack), .irq_req(irq_req), .pin(pin));
   toc_cpu_model u_toc_cpu_model (.clk(clk), .axi_req(axi_req),
      .axi_rsp(axi_rsp));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      u_toc_cpu_model.wr(a, v, r);
   endtask
   task automatic rd(input logic [7:0] a);
      u_toc_cpu_model.rd(a, d, r);
   endtask
   // Bounded wait; a miss shows up in the compare that follows
   task automatic wait_irq(input int b);
      int n;
      n = 0;
      while (irq_req[b] !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      #1;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(TOC_CTRL_OFS);
      check("ctrl", d, 32'h0);
      check("irq and pins", {irq_req, pin}, 10'h0);
      wr(TOC_MHI_BASE, 32'h12);
      wr(TOC_MLO_BASE, 32'h34);
      rd(TOC_MLO_BASE);
      check("match low", d, 32'h34);
      rd(TOC_MHI_BASE);
      check("match high", d, 32'h12);
      // Timer stopped: toggle action, pin A driven
      port_value <= 3'h1;
      wr(TOC_CTRL_OFS, 32'h00100100);
      check("override", {pin.oe, pin.value}, 6'h8);
      wr(TOC_FORCE_OFS, 32'h1);
      check("forced", pin.value[0], 1'b1);
      rd(TOC_FLAGS_OFS);
      check("no flag", d, 32'h0);
      port_value <= 3'h0;
      wr(TOC_CTRL_OFS, 32'h00100000);
      check("action off", pin.value[0], 1'b0);
      // Count up to the match with clear action and enabled interrupt
      wr(TOC_CNT_HI_OFS, 32'h12);
      wr(TOC_CNT_LO_OFS, 32'h30);
      wr(TOC_CTRL_OFS, 32'h00110210);
      wait_irq(0);
      check("irq a", irq_req, 4'h1);
      check("cleared pin", pin.value[0], 1'b0);
      wr(TOC_FLAGS_OFS, 32'h0);
      rd(TOC_FLAGS_OFS);
      check("flag kept", d, 32'h1);
      wr(TOC_FLAGS_OFS, 32'h1);
      rd(TOC_FLAGS_OFS);
      check("flag cleared", d, 32'h0);
      // Counter written equal to the match value while stopped
      wr(TOC_CTRL_OFS, 32'h0);
      wr(TOC_CNT_HI_OFS, 32'h12);
      wr(TOC_CNT_LO_OFS, 32'h34);
      wr(TOC_CTRL_OFS, 32'h00010010);
      repeat (10) @(posedge clk);
      rd(TOC_FLAGS_OFS);
      check("blocked match", d, 32'h0);
      // Wrap from the maximum in Normal mode
      wr(TOC_CNT_HI_OFS, 32'hff);
      wr(TOC_CNT_LO_OFS, 32'hfd);
      wr(TOC_CTRL_OFS, 32'h00080010);
      wait_irq(3);
      rd(TOC_FLAGS_OFS);
      // Count zero after the wrap also matches B and C, both still zero
      check("overflow", d, 32'he);
      rd(TOC_CNT_LO_OFS);
      rd(TOC_CNT_HI_OFS);
      check("wrapped high", d, 32'h0);
      // Clearing A and C must leave B and the overflow flag alone
      wr(TOC_FLAGS_OFS, 32'h5);
      rd(TOC_FLAGS_OFS);
      check("partial clear", d, 32'ha);
      irq_ack <= 4'ha;
      @(posedge clk);
      irq_ack <= 4'h0;
      @(posedge clk);
      #1;
      check("ack clears", irq_req, 4'h0);
      // Clear-on-match with channel A at 5 keeps the count in 0..5
      wr(TOC_CTRL_OFS, 32'h0);
      wr(TOC_MHI_BASE, 32'h0);
      wr(TOC_MLO_BASE, 32'h5);
      wr(TOC_CNT_LO_OFS, 32'h0);
      wr(TOC_CTRL_OFS, 32'h14);
      repeat (20) @(posedge clk);
      rd(TOC_FLAGS_OFS);
      check("ctc flags", d, 32'h7);
      rd(TOC_CNT_LO_OFS);
      check("ctc bound", 32'(d <= 32'h5), 32'h1);
      // Stopped fast PWM: the low write lands in the buffer only
      wr(TOC_CTRL_OFS, 32'h5);
      wr(TOC_MLO_BASE, 32'h77);
      rd(TOC_MLO_BASE);
      check("buffer", d, 32'h77);
      wr(TOC_CTRL_OFS, 32'h0);
      rd(TOC_MLO_BASE);
      check("active", d, 32'h5);
      wr(8'h2c, 32'h0);
      check("unmapped", r, TOC_RESP_SLVERR);
      tally_and_finish();
   end
endmodule
